/* hdl/hsrsc_defs.svh */
// Purpose: Constants for the headstage relay switch control block.
// Assumes: aclk runs at 10 MHz.
// Notes: Offsets are byte addresses on the AXI4-Lite register bus.
`ifndef HSRSC_DEFS_SVH
`define HSRSC_DEFS_SVH

// ************************************************************
// Pattern layout
// ************************************************************
`define HSRSC_PAT_BITS 24
`define HSRSC_CH_LSB 0
`define HSRSC_GND_BIT 16
`define HSRSC_REF_BIT 17
`define HSRSC_BANK_LSB 18
`define HSRSC_BANK_W 4

// ************************************************************
// Timing
// ************************************************************
`define HSRSC_CLK_HZ 10000000
`define HSRSC_RELAY_MS 2
`define HSRSC_INIT_MS 10
`define HSRSC_RELAY_CYC ((`HSRSC_CLK_HZ / 1000) * `HSRSC_RELAY_MS)
`define HSRSC_INIT_CYC ((`HSRSC_CLK_HZ / 1000) * `HSRSC_INIT_MS)

// ************************************************************
// Registers
// ************************************************************
`define HSRSC_REG_CTRL 8'h00
`define HSRSC_REG_STATUS 8'h04
`define HSRSC_REG_ROUTE 8'h08
`define HSRSC_REG_SHIFT 8'h0C
`define HSRSC_CTRL_RESET 32'h00000000

`endif

/* hdl/hsrsc_pkg.sv */
// Purpose: Types for the headstage relay switch control block.
// Assumes: Constants come from hsrsc_defs.svh.
// Notes: Holds states and carrier structs only.
package hsrsc_pkg;

  // Relay routing as applied to the drivers.
  typedef struct packed {
    logic ref_relay;
    logic gnd_relay;
    logic [15:0] stim_route;
  } hsrsc_route_t;

  // Link pins, raw or after synchronisation.
  typedef struct packed {
    logic clk;
    logic data;
    logic load_latch;
  } hsrsc_link_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    HSRSC_INIT = 2'b00,
    HSRSC_IDLE = 2'b01,
    HSRSC_SETTLE = 2'b10
  } hsrsc_state_t;

endpackage : hsrsc_pkg

/* hdl/hsrsc_sync.sv */
// Purpose: Two flip-flop synchroniser for the link pins.
// Assumes: Pins are asynchronous to aclk.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ps
module hsrsc_sync (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire hsrsc_pkg::hsrsc_link_t pins, // Raw link pins.
  output hsrsc_pkg::hsrsc_link_t synced // Synchronised link pins.
);
  import hsrsc_pkg::*;

  typedef struct packed {
    hsrsc_link_t s1;
    hsrsc_link_t s2;
  } hsrsc_sync_st_t;

  hsrsc_sync_st_t st;
  hsrsc_sync_st_t next_st;

  // Shift the pins through two stages.
  always_comb
  begin
    next_st.s1 = pins;
    next_st.s2 = st.s1;
  end

  // Register the stages.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign synced = st.s2;
endmodule : hsrsc_sync

/* hdl/hsrsc_axil.sv */
// Purpose: AXI4-Lite slave for the relay switch control registers.
// Assumes: One write and one read at a time.
// Notes: Address and data may arrive in either order.
`timescale 1ns/1ps
`include "hsrsc_defs.svh"
module hsrsc_axil (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [7:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  output logic [31:0] ctrl, // Control register.
  input wire logic [31:0] status, // Status word.
  input wire logic [31:0] route, // Applied route word.
  input wire logic [31:0] shift // Shift register word.
);
  import hsrsc_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] aw;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
  } hsrsc_axil_st_t;

  hsrsc_axil_st_t st;
  hsrsc_axil_st_t next_st;

  // Capture halves of a write, commit when both are in, answer reads.
  always_comb
  begin
    next_st = st;
    if (awvalid && !st.aw_got && !st.bvalid)
    begin
      next_st.aw_got = 1'b1;
      next_st.aw = awaddr;
    end
    if (wvalid && !st.w_got && !st.bvalid)
    begin
      next_st.w_got = 1'b1;
      next_st.wd = wdata;
      next_st.ws = wstrb;
    end
    if (st.aw_got && st.w_got)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = 2'b00;
      if (st.aw == `HSRSC_REG_CTRL)
      begin
        for (int i = 0; i < 4; i++)
          if (st.ws[i])
            next_st.ctrl[i*8 +: 8] = st.wd[i*8 +: 8];
      end
      else if (st.aw != `HSRSC_REG_STATUS && st.aw != `HSRSC_REG_ROUTE &&
               st.aw != `HSRSC_REG_SHIFT)
        next_st.bresp = 2'b10;
    end
    if (st.bvalid && bready)
      next_st.bvalid = 1'b0;
    if (arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = 2'b00;
      unique case (araddr)
        `HSRSC_REG_CTRL: next_st.rdata = st.ctrl;
        `HSRSC_REG_STATUS: next_st.rdata = status;
        `HSRSC_REG_ROUTE: next_st.rdata = route;
        `HSRSC_REG_SHIFT: next_st.rdata = shift;
        default:
        begin
          next_st.rdata = 32'h00000000;
          next_st.rresp = 2'b10;
        end
      endcase
    end
    else if (st.rvalid && rready)
      next_st.rvalid = 1'b0;
  end

  // Register the slave state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.ctrl <= `HSRSC_CTRL_RESET;
    end
    else
      st <= next_st;
  end

  assign awready = !st.aw_got && !st.bvalid;
  assign wready = !st.w_got && !st.bvalid;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = !st.rvalid;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = st.rdata;
  assign ctrl = st.ctrl;
endmodule : hsrsc_axil

/* hdl/hsrsc_top.sv */
// Purpose: Relay switch control of a 16-channel switchable headstage.
// Assumes: Link pins are asynchronous; aclk is 10 MHz.
// Notes: Routing changes only after a load/latch pulse plus relay delay.
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "hsrsc_defs.svh"

// Functional notes
// - Routing comes from a 24-bit serial control pattern.
// - Relays apply new routing 2 ms after the pattern is latched.
// - Total switching time is pattern transfer plus relay delay.
// - Selected channels go to stimulator; others stay on the preamp.
// - Routing is invalid until 10 ms after start.
// - A relay ties electrode ground to preamp ground.
// - A relay ties electrode reference to preamp reference.
module hsrsc_top (
  input wire logic aclk, // System clock, 10 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic link_clk, // Serial clock pin.
  input wire logic link_data, // Serial data pin.
  input wire logic load_latch, // Load/latch pin.
  output logic stimulator_detect, // Headstage present indicator.
  output logic [15:0] stim_route, // Per channel: 1 to stimulator.
  output logic [15:0] rec_route, // Per channel: 1 to preamp.
  output logic gnd_relay, // Electrode ground tied to preamp ground.
  output logic ref_relay, // Electrode reference tied to preamp reference.
  output logic route_valid, // Routing valid for use.
  input wire logic [7:0] awaddr, // AXI write address.
  input wire logic awvalid, // AXI write address valid.
  output logic awready, // AXI write address ready.
  input wire logic [31:0] wdata, // AXI write data.
  input wire logic [3:0] wstrb, // AXI write strobes.
  input wire logic wvalid, // AXI write data valid.
  output logic wready, // AXI write data ready.
  output logic [1:0] bresp, // AXI write response.
  output logic bvalid, // AXI write response valid.
  input wire logic bready, // AXI write response ready.
  input wire logic [7:0] araddr, // AXI read address.
  input wire logic arvalid, // AXI read address valid.
  output logic arready, // AXI read address ready.
  output logic [31:0] rdata, // AXI read data.
  output logic [1:0] rresp, // AXI read response.
  output logic rvalid, // AXI read data valid.
  input wire logic rready // AXI read data ready.
);
  import hsrsc_pkg::*;

  localparam int RELAY_CYC = `HSRSC_RELAY_CYC;
  localparam int INIT_CYC = `HSRSC_INIT_CYC;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    hsrsc_state_t fsm;
    logic [17:0] timer;
    logic clk_d;
    logic lat_d;
    logic [`HSRSC_PAT_BITS-1:0] shreg;
    logic [4:0] nbits;
    logic [`HSRSC_PAT_BITS-1:0] latched;
    hsrsc_route_t route;
    logic [15:0] rec;
    logic valid;
    logic pending;
    logic [7:0] ignored;
    logic detect;
  } hsrsc_top_st_t;

  hsrsc_top_st_t st;
  hsrsc_top_st_t next_st;
  hsrsc_link_t pins;
  hsrsc_link_t link;
  logic [31:0] ctrl;
  logic [31:0] status_w;
  logic [31:0] route_w;
  logic [31:0] shift_w;
  logic clk_rise;
  logic lat_rise;
  logic bank_hit;
  hsrsc_route_t new_route;

  // ************************************************************
  // Link input synchronisation
  // ************************************************************
  // All routing patterns enter through the stimulator port pins; the bank number comes from the CTRL register.
  assign pins = '{clk: link_clk, data: link_data,
                  load_latch: load_latch};

  hsrsc_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(pins),
    .synced(link)
  );

  // Edges are found on the synchronised copies only.
  assign clk_rise = link.clk && !st.clk_d;
  assign lat_rise = link.load_latch && !st.lat_d;

  // The bank field in the pattern must match this headstage's bank.
  assign bank_hit = st.shreg[`HSRSC_BANK_LSB +: `HSRSC_BANK_W] ==
                    ctrl[`HSRSC_BANK_W-1:0];

  // Decode a latched pattern into relay settings.
  always_comb
  begin
    new_route.stim_route = st.latched[`HSRSC_CH_LSB +: 16];
    new_route.gnd_relay = st.latched[`HSRSC_GND_BIT];
    new_route.ref_relay = st.latched[`HSRSC_REF_BIT];
  end

  // ************************************************************
  // Shifter, latch and relay sequencer
  // ************************************************************
  // A latch seen during the relay settle restarts the settle with the
  // newer pattern; the relays never see a half-applied pattern.
  always_comb
  begin
    next_st = st;
    next_st.clk_d = link.clk;
    next_st.lat_d = link.load_latch;
    next_st.detect = 1'b1;
    if (clk_rise)
    begin
      next_st.shreg = {st.shreg[`HSRSC_PAT_BITS-2:0], link.data};
      if (st.nbits != 5'(`HSRSC_PAT_BITS))
        next_st.nbits = st.nbits + 5'd1;
    end
    if (lat_rise)
    begin
      next_st.nbits = 5'd0;
      if (st.nbits == 5'(`HSRSC_PAT_BITS) && bank_hit)
      begin
        next_st.latched = st.shreg;
        next_st.pending = 1'b1;
      end
      else
        next_st.ignored = st.ignored + 8'd1;
    end
    if (st.timer != 18'd0)
      next_st.timer = st.timer - 18'd1;
    unique case (st.fsm)
      HSRSC_INIT:
      begin
        // The full count runs out first, so routing is never valid early.
        if (st.timer == 18'd0)
        begin
          next_st.valid = 1'b1;
          next_st.fsm = HSRSC_IDLE;
        end
      end
      HSRSC_IDLE:
      begin
        if (st.pending)
        begin
          next_st.pending = 1'b0;
          next_st.timer = 18'(RELAY_CYC);
          next_st.fsm = HSRSC_SETTLE;
        end
      end
      HSRSC_SETTLE:
      begin
        if (st.pending)
        begin
          next_st.pending = 1'b0;
          next_st.timer = 18'(RELAY_CYC);
        end
        else if (st.timer == 18'd1)
        begin
          next_st.route = new_route;
          next_st.rec = ~new_route.stim_route;
          next_st.fsm = HSRSC_IDLE;
        end
      end
      default:
        next_st.fsm = HSRSC_IDLE;
    endcase
    if (lat_rise && next_st.pending == 1'b0 && st.fsm != HSRSC_INIT &&
        st.nbits == 5'(`HSRSC_PAT_BITS) && bank_hit)
      next_st.pending = 1'b1;
  end

  // Register all state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.fsm <= HSRSC_INIT;
      st.timer <= 18'(INIT_CYC);
      // Every channel sits on the preamp path out of reset.
      st.rec <= 16'hFFFF;
    end
    else
      st <= next_st;
  end

  // ************************************************************
  // Registers and outputs
  // ************************************************************
  assign status_w = {16'h0000, st.ignored, 3'b000,
                     st.nbits == 5'(`HSRSC_PAT_BITS), st.pending,
                     st.fsm == HSRSC_SETTLE, st.valid, st.fsm == HSRSC_INIT};
  assign route_w = {14'h0000, st.route};
  assign shift_w = {8'h00, st.shreg};

  hsrsc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .ctrl(ctrl),
    .status(status_w),
    .route(route_w),
    .shift(shift_w)
  );

  // Routing outputs come straight from state flip-flops.
  assign stim_route = st.route.stim_route;
  assign rec_route = st.rec;
  assign gnd_relay = st.route.gnd_relay;
  assign ref_relay = st.route.ref_relay;
  assign route_valid = st.valid;
  assign stimulator_detect = st.detect;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_relay_delay;
    @(posedge aclk) disable iff (!aresetn)
    (st.fsm == HSRSC_SETTLE && st.timer == 18'd1 && !st.pending)
      |=> stim_route == $past(new_route.stim_route);
  endproperty
  a_relay_delay: assert property (p_relay_delay)
    else $error("relay routing not applied after delay");

  property p_no_change_idle;
    @(posedge aclk) disable iff (!aresetn)
    (st.fsm == HSRSC_IDLE && !st.pending) |=> $stable(stim_route);
  endproperty
  a_no_change_idle: assert property (p_no_change_idle)
    else $error("routing changed without latch");

  property p_split;
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |-> (stim_route ^ rec_route) == 16'hFFFF;
  endproperty
  a_split: assert property (p_split)
    else $error("channel on both or neither path");

  property p_init_invalid;
    @(posedge aclk) disable iff (!aresetn)
    (st.fsm == HSRSC_INIT) |-> !route_valid;
  endproperty
  a_init_invalid: assert property (p_init_invalid)
    else $error("routing valid before init");

  property p_shift;
    @(posedge aclk) disable iff (!aresetn)
    clk_rise |=> st.shreg[0] == $past(link.data);
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial bit not shifted");

  property p_latch;
    @(posedge aclk) disable iff (!aresetn)
    (lat_rise && st.nbits == 5'(`HSRSC_PAT_BITS) && bank_hit)
      |=> st.latched == $past(st.shreg);
  endproperty
  a_latch: assert property (p_latch)
    else $error("full pattern not latched");

  property p_gnd;
    @(posedge aclk) disable iff (!aresetn)
    $changed(gnd_relay) |-> $past(st.fsm) == HSRSC_SETTLE;
  endproperty
  a_gnd: assert property (p_gnd)
    else $error("ground relay moved outside settle");

  property p_ref;
    @(posedge aclk) disable iff (!aresetn)
    $changed(ref_relay) |-> $past(st.fsm) == HSRSC_SETTLE;
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference relay moved outside settle");
endmodule : hsrsc_top

/* test/hsrsc_base.sv */
// Purpose: Behavioural model of the base station that drives the relay link.
// Assumes: The headstage samples these pins with its own clock.
// Notes: The serial clock runs only inside frames, at an 800 ns period.
`timescale 1ns/1ps
module hsrsc_base (
  output logic link_clk, // Serial clock pin.
  output logic link_data, // Serial data pin.
  output logic load_latch // Load/latch pin.
);
  import hsrsc_pkg::*;

  // ************************************************************
  // Pin drive
  // ************************************************************

  // Every control line comes from this model and nowhere else.
  initial
  begin
    link_clk = 1'b0;
    link_data = 1'b0;
    load_latch = 1'b0;
  end

  // Builds a pattern from a channel mask, relay bits and a bank number.
  function automatic logic [23:0] make_pat(input logic [15:0] mask,
    input logic gnd, input logic rf, input logic [3:0] bank);
    return {2'b00, bank, rf, gnd, mask};
  endfunction : make_pat

  // Shifts nbits out, most significant first, then pulses load/latch.
  // The data line has no pull, so after a frame it shows the inverse of
  // its last bit; a receiver that samples late cannot pass by luck.
  task automatic frame(input logic [23:0] pat, input int nbits,
    input bit latch);
    #137;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      link_data = pat[i];
      #400 link_clk = 1'b1;
      #400 link_clk = 1'b0;
    end
    link_data = ~link_data;
    if (latch)
    begin
      #400 load_latch = 1'b1;
      #1600 load_latch = 1'b0;
    end
  endtask : frame
endmodule : hsrsc_base

/* test/testbench.sv */
// Purpose: Self-checking bench for the headstage relay switch control.
// Assumes: aclk is 10 MHz; the init count of 10 ms cannot be shortened.
// Notes: Drivers note expectations in queues; a monitor pops and compares.
`timescale 1ns/1ps
`include "hsrsc_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((e) !== (g)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
  import hsrsc_pkg::*;

  logic aclk = 1'b0;
  logic aresetn, link_clk, link_data, load_latch, stimulator_detect;
  logic [15:0] stim_route, rec_route;
  logic gnd_relay, ref_relay, route_valid;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [65:0] rq[$];
  logic [81:0] nq[$];
  logic [65:0] re;
  logic [81:0] ne;
  logic [1:0] bq[$];
  logic [1:0] be;
  logic in_win;
  logic [17:0] prev, cur;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 61;

  // ************************************************************
  // Clock, design and partner
  // ************************************************************
  always #50 aclk = ~aclk;

  hsrsc_top hsrsc_top_inst (.aclk(aclk), .aresetn(aresetn),
    .link_clk(link_clk), .link_data(link_data), .load_latch(load_latch),
    .stimulator_detect(stimulator_detect), .stim_route(stim_route),
    .rec_route(rec_route), .gnd_relay(gnd_relay), .ref_relay(ref_relay),
    .route_valid(route_valid), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  hsrsc_base hsrsc_base_inst (.link_clk(link_clk), .link_data(link_data),
    .load_latch(load_latch));

  // ************************************************************
  // Tasks
  // ************************************************************

  // Prints the verdict and ends the run.
  task give_verdict;
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // A wait that ran out counts as a mismatch and ends the run.
  task timed_out(input string nm);
    fails++;
    $display("Error %s expected %h seen %h", nm, 1'b1, 1'b0);
    give_verdict();
  endtask : timed_out

  // AXI4-Lite write; address and data are released as each is taken.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid === 1'b1 && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid === 1'b1 && wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100)
      timed_out("bvalid");
    bready <= 1'b0;
  endtask : wr

  // AXI4-Lite read; the expectation is queued for the monitor.
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] er);
    int n;
    rq.push_back({m, er, e});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid === 1'b1 && arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100)
      timed_out("rvalid");
    rready <= 1'b0;
  endtask : rd

  // Waits, bounded, until every noted route change has been seen.
  task wait_applied;
    int n;
    n = 0;
    while (nq.size() != 0 && n < 21000)
    begin
      @(posedge aclk);
      n++;
    end
    if (nq.size() != 0)
      timed_out("route_applied");
  endtask : wait_applied

  // ************************************************************
  // Monitor
  // ************************************************************

  // Any change of the relay outputs must match the oldest note, inside
  // its time window; a change with no note pending is a fault.
  always @(posedge aclk)
  begin
    cur = {ref_relay, gnd_relay, stim_route};
    if (aresetn !== 1'b1)
    begin
      prev <= cur;
      cyc <= 0;
    end
    else
    begin
      cyc <= cyc + 1;
      if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
      begin
        re = rq.pop_front();
        `CHK("rdata", re[31:0], rdata & re[65:34]);
        `CHK("rresp", re[33:32], rresp);
      end
      if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
      begin
        be = bq.pop_front();
        `CHK("bresp", be, bresp);
      end
      if (cur !== prev && nq.size() == 0)
        `CHK("route_change", prev, cur)
      else if (cur !== prev)
      begin
        ne = nq.pop_front();
        `CHK("route", ne[81:64], cur);
        `CHK("rec_route", ~ne[79:64], rec_route);
        in_win = cyc >= ne[63:32] && cyc <= ne[31:0];
        `CHK("settle_time", 1'b1, in_win);
      end
      prev <= cur;
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin : main
    logic [15:0] m;
    logic g;
    logic r;
    logic [23:0] p;
    aresetn <= 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready} <= '0;
    {araddr, arvalid, rready} <= '0;
    wstrb <= 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    #1;
    `CHK("stim_route", 16'h0000, stim_route);
    `CHK("rec_route", 16'hFFFF, rec_route);
    `CHK("relays", 2'b00, {ref_relay, gnd_relay});
    `CHK("route_valid", 1'b0, route_valid);
    `CHK("detect", 1'b1, stimulator_detect);
    rd(`HSRSC_REG_CTRL, 32'hFFFFFFFF, `HSRSC_CTRL_RESET, 2'b00);
    rd(8'h10, 32'hFFFFFFFF, 32'h00000000, 2'b10);
    wr(8'h10, 32'h00000000, 2'b10);
    wr(`HSRSC_REG_CTRL, 32'h00000005, 2'b00);
    rd(`HSRSC_REG_CTRL, 32'h0000000F, 32'h00000005, 2'b00);
    // A latch during init is held and applied only after init ends.
    m = 16'h0001 << (7 - 1);
    nq.push_back({2'b01, m, 32'd100000, 32'd120040});
    hsrsc_base_inst.frame(hsrsc_base_inst.make_pat(m, 1'b1, 1'b0, 4'h5),
      24, 1'b1);
    while (route_valid !== 1'b1 && cyc < 100100)
      @(posedge aclk);
    if (route_valid !== 1'b1)
      timed_out("route_valid");
    `CHK("init_time", 1'b1, cyc >= 99999 && cyc <= 100005);
    wait_applied();
    // Random masks and relay bits through full frames.
    for (int k = 0; k < 2; k++)
    begin
      m = 16'($random(seed));
      g = 1'($random(seed));
      r = 1'($random(seed));
      p = hsrsc_base_inst.make_pat(m, g, r, 4'h5);
      hsrsc_base_inst.frame(p, 24, 1'b1);
      nq.push_back({r, g, m, 32'(cyc + 19970), 32'(cyc + 20010)});
      wait_applied();
      rd(`HSRSC_REG_ROUTE, 32'h0003FFFF, {14'h0000, r, g, m}, 2'b00);
      rd(`HSRSC_REG_SHIFT, 32'h00FFFFFF, {8'h00, p}, 2'b00);
    end
    // Wrong bank, then a short frame: both are refused and counted.
    p = hsrsc_base_inst.make_pat(16'hFFFF, 1'b1, 1'b1, 4'h6);
    hsrsc_base_inst.frame(p, 24, 1'b1);
    p = hsrsc_base_inst.make_pat(16'hFFFF, 1'b1, 1'b1, 4'h5);
    hsrsc_base_inst.frame(p, 23, 1'b1);
    repeat (20100) @(posedge aclk);
    rd(`HSRSC_REG_STATUS, 32'h0000FF0E, 32'h00000202, 2'b00);
    give_verdict();
  end
endmodule : testbench
